/* core/parallel_io_ports.sv */
// four 8-bit parallel i/o ports with bit latches, pin sampling,
// external memory multiplexing and alternate-function routing.
// assumes the cpu issues one latch write or one read at a time on mclk,
// and the pad ring resolves each pin from out/oe plus the weak pull-up.
//
// Operation
// - port zero open-drain, follows latch when idle
// - port zero carries low address and data
// - every port bit latches bus on write
// - latch read returns latch, pin read pin
// - external access fills port zero latch ones
// - external select drives port zero push-pull
// - port zero latch one floats, zero drives
// - analog port never drives its pins
// - analog port resets ones; zero selects digital
// - analog pins feed timer and slave select
// - high port outputs upper address bytes
// - external addressing drives high port, latch kept
// - high port one pulls up, zero drives
// - configured pwm overrides high port bits six, seven
// - special port one pulls up, zero drives
// - alternate output passes only with latch one
// - special port carries serial, interrupt, timer, strobes
// - configured pwm overrides special bits three, four
// - read classes select latch or pin
// - modify-write reads latch, bit rewrites byte
module parallel_io_ports
  import pio_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  // cpu latch write
  input wire logic latch_wr,
  input wire logic [1:0] wr_port,
  input wire logic [7:0] wr_data,
  input wire logic bit_wr,
  input wire logic [2:0] bit_idx,
  input wire logic bit_val,
  // cpu read
  input wire logic rd_req,
  input wire logic [1:0] rd_port,
  input wire logic rd_latch_class,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // external memory
  input wire logic ext_mem_active,
  input wire logic [7:0] ext_addr_data_out,
  input wire logic ext_addr_high_active,
  input wire logic [7:0] ext_addr_high,
  output logic [7:0] ext_data_in,
  input wire logic ext_wr_n,
  input wire logic ext_rd_n,
  // chip configuration
  input wire logic pwm_on_high_port,
  input wire logic pwm_on_special_port,
  input wire logic pwm0,
  input wire logic pwm1,
  // serial peripheral outputs
  input wire logic shift_mode,
  input wire logic serial_tx_out,
  input wire logic shift_data_out,
  input wire logic shift_clk_out,
  // alternate inputs
  output logic third_timer_count_input,
  output logic third_timer_trigger_input,
  output logic slave_select_n,
  output logic serial_rx_in,
  output logic external_interrupt_zero,
  output logic external_interrupt_one,
  output logic first_timer_count_input,
  output logic second_timer_count_input,
  output logic [7:0] analog_select,
  // pins
  input wire logic [7:0] addr_data_pin_in,
  output logic [7:0] addr_data_pin_out,
  output logic [7:0] addr_data_pin_oe,
  input wire logic [7:0] analog_pin_in,
  input wire logic [7:0] high_addr_pin_in,
  output logic [7:0] high_addr_pin_out,
  output logic [7:0] high_addr_pin_oe,
  output logic [7:0] high_addr_pullup,
  input wire logic [7:0] special_pin_in,
  output logic [7:0] special_pin_out,
  output logic [7:0] special_pin_oe,
  output logic [7:0] special_pullup
);
  import pio_pkg::*;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] port_onehot(input logic [1:0] sel);
    port_onehot = 4'h1 << sel;
  endfunction

  function automatic logic [7:0] set_bit(input logic [7:0] val, input logic [2:0] idx, input logic b);
    logic [7:0] mask;
    mask = 8'h01 << idx;
    set_bit = b ? (val | mask) : (val & ~mask);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] addr_data_port_latch_reg;
  logic [7:0] analog_input_port_latch_reg;
  logic [7:0] high_address_port_latch_reg;
  logic [7:0] special_function_port_latch_reg;
  logic [7:0] pin_meta_reg [NUM_PORTS];
  logic [7:0] pin_sync_reg [NUM_PORTS];
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic [7:0] ext_data_in_reg;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic [3:0] wr_hit;
  logic [3:0] bit_hit;
  logic [7:0] latch_cur [NUM_PORTS];
  logic [7:0] latch_next [NUM_PORTS];
  logic [7:0] bit_merged;

  assign wr_hit = latch_wr ? port_onehot(wr_port) : 4'h0;
  assign bit_hit = (bit_wr && !latch_wr) ? port_onehot(wr_port) : 4'h0;
  assign latch_cur[0] = addr_data_port_latch_reg;
  assign latch_cur[1] = analog_input_port_latch_reg;
  assign latch_cur[2] = high_address_port_latch_reg;
  assign latch_cur[3] = special_function_port_latch_reg;
  // a single-bit write merges into the whole latched byte, not the pins
  assign bit_merged = set_bit(latch_cur[wr_port], bit_idx, bit_val);

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_next
      assign latch_next[gp] = wr_hit[gp] ? wr_data :
                              bit_hit[gp] ? bit_merged : latch_cur[gp];
    end
  endgenerate

  // ----------------------------------------------------------------
  // bit latches
  // ----------------------------------------------------------------
  // external access fill wins over a cpu write in the same cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_data_port_latch_reg <= LATCH_RESET;
      analog_input_port_latch_reg <= LATCH_RESET;
      high_address_port_latch_reg <= LATCH_RESET;
      special_function_port_latch_reg <= LATCH_RESET;
    end
    else
    begin
      addr_data_port_latch_reg <= ext_mem_active ? ADDR_DATA_ACCESS_FILL : latch_next[0];
      analog_input_port_latch_reg <= latch_next[1];
      high_address_port_latch_reg <= latch_next[2];
      special_function_port_latch_reg <= latch_next[3];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_raw [NUM_PORTS];
  assign pin_raw[0] = addr_data_pin_in;
  assign pin_raw[1] = analog_pin_in;
  assign pin_raw[2] = high_addr_pin_in;
  assign pin_raw[3] = special_pin_in;

  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_sync
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          pin_meta_reg[gp] <= PIN_SYNC_RESET;
          pin_sync_reg[gp] <= PIN_SYNC_RESET;
        end
        else
        begin
          pin_meta_reg[gp] <= pin_raw[gp];
          pin_sync_reg[gp] <= pin_meta_reg[gp];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // cpu read path
  // ----------------------------------------------------------------
  // modify-write instructions use the latch class so a loaded pin
  // cannot corrupt the value written back
  logic [7:0] rd_sel;
  assign rd_sel = rd_latch_class ? latch_cur[rd_port] : pin_sync_reg[rd_port];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      ext_data_in_reg <= 8'h00;
    end
    else
    begin
      rd_valid_reg <= rd_req;
      if (rd_req)
      begin
        rd_data_reg <= rd_sel;
      end
      ext_data_in_reg <= pin_sync_reg[0];
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign ext_data_in = ext_data_in_reg;

  // ----------------------------------------------------------------
  // address/data port drive
  // ----------------------------------------------------------------
  // no pull-up in gpio mode: a latched one only releases the pin
  assign addr_data_pin_out = ext_mem_active ? ext_addr_data_out : 8'h00;
  assign addr_data_pin_oe = ext_mem_active ? 8'hff : ~addr_data_port_latch_reg;

  // ----------------------------------------------------------------
  // analog input port
  // ----------------------------------------------------------------
  // input only: there is no output driver on these pins at all
  assign analog_select = analog_input_port_latch_reg;
  assign third_timer_count_input = pin_sync_reg[1][BIT_THIRD_TIMER_COUNT];
  assign third_timer_trigger_input = pin_sync_reg[1][BIT_THIRD_TIMER_TRIGGER];
  assign slave_select_n = pin_sync_reg[1][BIT_SLAVE_SELECT];

  // ----------------------------------------------------------------
  // high address port drive
  // ----------------------------------------------------------------
  logic [7:0] high_level;
  assign high_level = pwm_on_high_port ?
    {pwm1, pwm0, high_address_port_latch_reg[5:0]} : high_address_port_latch_reg;
  assign high_addr_pin_out = ext_addr_high_active ? ext_addr_high : 8'h00;
  assign high_addr_pin_oe = ext_addr_high_active ? 8'hff : ~high_level;
  assign high_addr_pullup = ext_addr_high_active ? 8'h00 : high_level;

  // ----------------------------------------------------------------
  // special function port drive
  // ----------------------------------------------------------------
  // unused alternate outputs idle high so the latch alone decides
  logic [7:0] alt_out;
  logic [7:0] special_level;
  logic [7:0] special_gated;
  assign alt_out[BIT_SERIAL_RX] = shift_mode ? shift_data_out : 1'b1;
  assign alt_out[BIT_SERIAL_TX] = shift_mode ? shift_clk_out : serial_tx_out;
  assign alt_out[BIT_EXT_INT_ZERO] = 1'b1;
  assign alt_out[BIT_EXT_INT_ONE] = 1'b1;
  assign alt_out[BIT_FIRST_TIMER] = 1'b1;
  assign alt_out[BIT_SECOND_TIMER] = 1'b1;
  assign alt_out[BIT_WRITE_STROBE] = ext_wr_n;
  assign alt_out[BIT_READ_STROBE] = ext_rd_n;
  // a latched zero holds the pin low whatever the peripheral does, except bits three and four while pwm is on the special port
  assign special_gated = special_function_port_latch_reg & alt_out;

  genvar gb;
  generate
    for (gb = 0; gb < PORT_WIDTH; gb++)
    begin : g_special
      if (gb == BIT_SPECIAL_PWM0)
      begin : g_pwm0
        assign special_level[gb] = pwm_on_special_port ? pwm0 : special_gated[gb];
      end
      else if (gb == BIT_SPECIAL_PWM1)
      begin : g_pwm1
        assign special_level[gb] = pwm_on_special_port ? pwm1 : special_gated[gb];
      end
      else
      begin : g_plain
        assign special_level[gb] = special_gated[gb];
      end
    end
  endgenerate

  assign special_pin_out = 8'h00;
  assign special_pin_oe = ~special_level;
  assign special_pullup = special_level;

  assign serial_rx_in = pin_sync_reg[3][BIT_SERIAL_RX];
  assign external_interrupt_zero = pin_sync_reg[3][BIT_EXT_INT_ZERO];
  assign external_interrupt_one = pin_sync_reg[3][BIT_EXT_INT_ONE];
  assign first_timer_count_input = pin_sync_reg[3][BIT_FIRST_TIMER];
  assign second_timer_count_input = pin_sync_reg[3][BIT_SECOND_TIMER];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_latch_write_taken: assert property (latch_wr |=> latch_cur[$past(wr_port)] == $past(wr_data)
    || ($past(ext_mem_active) && $past(wr_port) == PORT_ADDR_DATA))
    else $error("latch write not stored");
  a_fill_on_access: assert property (ext_mem_active |=> addr_data_port_latch_reg == ADDR_DATA_ACCESS_FILL)
    else $error("address/data latch not filled during access");
  a_read_pin_class: assert property (rd_req && !rd_latch_class
    |=> rd_valid && rd_data == $past(pin_sync_reg[rd_port]))
    else $error("pin read returned wrong value");
  a_read_latch_class: assert property (rd_req && rd_latch_class && !latch_wr && !bit_wr && !ext_mem_active
    |=> rd_data == latch_cur[$past(rd_port)])
    else $error("latch read returned wrong value");
  a_open_drain_idle: assert property (!ext_mem_active |-> addr_data_pin_oe == ~addr_data_port_latch_reg
    && addr_data_pin_out == 8'h00)
    else $error("address/data port not open-drain");
  a_push_pull_access: assert property (ext_mem_active |-> addr_data_pin_oe == 8'hff
    && addr_data_pin_out == ext_addr_data_out)
    else $error("address/data port not driven during access");
  a_high_latch_kept: assert property (ext_addr_high_active && !latch_wr && !bit_wr
    |=> $stable(high_address_port_latch_reg))
    else $error("high address latch changed by access");
  a_high_addr_out: assert property (ext_addr_high_active
    |-> high_addr_pin_out == ext_addr_high && high_addr_pullup == 8'h00)
    else $error("high port not carrying address");
  a_high_gpio_drive: assert property (!ext_addr_high_active && !pwm_on_high_port
    |-> high_addr_pin_oe == ~high_address_port_latch_reg && high_addr_pullup == high_address_port_latch_reg)
    else $error("high port gpio drive wrong");
  a_high_pwm_override: assert property (pwm_on_high_port && !ext_addr_high_active
    |-> high_addr_pin_oe[BIT_HIGH_PWM1] == !pwm1 && high_addr_pin_oe[BIT_HIGH_PWM0] == !pwm0)
    else $error("pwm did not override high port");
  a_special_stuck_low: assert property (!special_function_port_latch_reg[BIT_SERIAL_TX]
    |-> special_pin_oe[BIT_SERIAL_TX])
    else $error("alternate output passed a latched zero");
  a_special_pwm: assert property (pwm_on_special_port
    |-> special_pullup[BIT_SPECIAL_PWM1] == pwm1 && special_pullup[BIT_SPECIAL_PWM0] == pwm0)
    else $error("pwm did not override special port");
  a_bit_rewrite: assert property (bit_wr && !latch_wr && !ext_mem_active
    |=> latch_cur[$past(wr_port)][$past(bit_idx)] == $past(bit_val)
    && (latch_cur[$past(wr_port)] | (8'h01 << $past(bit_idx)))
    == ($past(latch_cur[wr_port]) | (8'h01 << $past(bit_idx))))
    else $error("bit write did not rewrite latched byte");

endmodule

/* core/pio_pkg.sv */
// constants shared by the four-port parallel i/o block
// assumes a single core clock domain and an active-low async reset
package pio_pkg;

  // ----------------------------------------------------------------
  // port identifiers
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_ADDR_DATA = 2'h0;
  localparam logic [1:0] PORT_ANALOG = 2'h1;
  localparam logic [1:0] PORT_HIGH_ADDR = 2'h2;
  localparam logic [1:0] PORT_SPECIAL = 2'h3;
  localparam int NUM_PORTS = 4;
  localparam int PORT_WIDTH = 8;

  // ----------------------------------------------------------------
  // reset and access-fill values of the bit latches, and pin synchroniser reset
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] ADDR_DATA_ACCESS_FILL = 8'hff;
  localparam logic [7:0] PIN_SYNC_RESET = 8'hff;

  // ----------------------------------------------------------------
  // analog input port alternate inputs
  // ----------------------------------------------------------------
  localparam int BIT_THIRD_TIMER_COUNT = 0;
  localparam int BIT_THIRD_TIMER_TRIGGER = 1;
  localparam int BIT_SLAVE_SELECT = 5;

  // ----------------------------------------------------------------
  // high address port pwm pins
  // ----------------------------------------------------------------
  localparam int BIT_HIGH_PWM0 = 6;
  localparam int BIT_HIGH_PWM1 = 7;

  // ----------------------------------------------------------------
  // special function port pins
  // ----------------------------------------------------------------
  localparam int BIT_SERIAL_RX = 0;
  localparam int BIT_SERIAL_TX = 1;
  localparam int BIT_EXT_INT_ZERO = 2;
  localparam int BIT_EXT_INT_ONE = 3;
  localparam int BIT_FIRST_TIMER = 4;
  localparam int BIT_SECOND_TIMER = 5;
  localparam int BIT_WRITE_STROBE = 6;
  localparam int BIT_READ_STROBE = 7;
  localparam int BIT_SPECIAL_PWM1 = 3;
  localparam int BIT_SPECIAL_PWM0 = 4;

endpackage

/* dv/pin_partner.sv */
// pad ring and external devices on the four ports
// assumes the bench chooses what the far side drives through the en/val pairs
module pin_partner
(
  input wire logic mclk,
  input wire logic [7:0] addr_data_pin_out,
  input wire logic [7:0] addr_data_pin_oe,
  input wire logic [7:0] high_addr_pin_out,
  input wire logic [7:0] high_addr_pin_oe,
  input wire logic [7:0] high_addr_pullup,
  input wire logic [7:0] special_pin_out,
  input wire logic [7:0] special_pin_oe,
  input wire logic [7:0] special_pullup,
  input wire logic [7:0] p0_en,
  input wire logic [7:0] p0_val,
  input wire logic [7:0] p1_en,
  input wire logic [7:0] p1_val,
  input wire logic [7:0] p2_en,
  input wire logic [7:0] p2_val,
  input wire logic [7:0] p3_en,
  input wire logic [7:0] p3_val,
  output logic [7:0] addr_data_pin_in,
  output logic [7:0] analog_pin_in,
  output logic [7:0] high_addr_pin_in,
  output logic [7:0] special_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // undriven lines with no pull-up wander, so a stale level never reads back
  logic [7:0] float_reg = 8'h55;
  always @(posedge mclk) float_reg <= ~float_reg;
  function automatic logic [7:0] pad(input logic [7:0] o, oe, pu, en, v, fl);
    return (oe & o) | (~oe & en & v) | (~oe & ~en & pu) | (~oe & ~en & ~pu & fl);
  endfunction
  assign addr_data_pin_in = pad(addr_data_pin_out, addr_data_pin_oe, 8'h00, p0_en, p0_val, float_reg);
  assign analog_pin_in = pad(8'h00, 8'h00, 8'h00, p1_en, p1_val, float_reg);
  assign high_addr_pin_in = pad(high_addr_pin_out, high_addr_pin_oe, high_addr_pullup, p2_en, p2_val, float_reg);
  assign special_pin_in = pad(special_pin_out, special_pin_oe, special_pullup, p3_en, p3_val, float_reg);
endmodule

/* dv/tb.sv */
// directed bench for the four-port parallel i/o block
// assumes pin_partner models the board; inputs move 1 ns after mclk rises
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pio_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic latch_wr, bit_wr, bit_val, rd_req, rd_latch_class, rd_valid, ext_mem_active, ext_addr_high_active;
  logic ext_wr_n, ext_rd_n, pwm_on_high_port, pwm_on_special_port, pwm0, pwm1, shift_mode;
  logic serial_tx_out, shift_data_out, shift_clk_out, third_timer_count_input, third_timer_trigger_input;
  logic slave_select_n, serial_rx_in, external_interrupt_zero, external_interrupt_one;
  logic first_timer_count_input, second_timer_count_input;
  logic [1:0] wr_port, rd_port;
  logic [2:0] bit_idx;
  logic [7:0] wr_data, rd_data, ext_addr_data_out, ext_addr_high, ext_data_in, analog_select;
  logic [7:0] addr_data_pin_in, addr_data_pin_out, addr_data_pin_oe, analog_pin_in, high_addr_pin_in;
  logic [7:0] high_addr_pin_out, high_addr_pin_oe, high_addr_pullup, special_pin_in, special_pin_out;
  logic [7:0] special_pin_oe, special_pullup, p0_en, p0_val, p1_en, p1_val, p2_en, p2_val, p3_en, p3_val;
  int n_fail = 0;
  int samples_checked = 0;
  always #4 mclk = ~mclk;

  parallel_io_ports uut (.mclk, .nrst, .latch_wr, .wr_port, .wr_data, .bit_wr, .bit_idx, .bit_val, .rd_req,
    .rd_port, .rd_latch_class, .rd_data, .rd_valid, .ext_mem_active, .ext_addr_data_out, .ext_addr_high_active,
    .ext_addr_high, .ext_data_in, .ext_wr_n, .ext_rd_n, .pwm_on_high_port, .pwm_on_special_port, .pwm0, .pwm1,
    .shift_mode, .serial_tx_out, .shift_data_out, .shift_clk_out, .third_timer_count_input,
    .third_timer_trigger_input, .slave_select_n, .serial_rx_in, .external_interrupt_zero, .external_interrupt_one,
    .first_timer_count_input, .second_timer_count_input, .analog_select, .addr_data_pin_in, .addr_data_pin_out,
    .addr_data_pin_oe, .analog_pin_in, .high_addr_pin_in, .high_addr_pin_out, .high_addr_pin_oe, .high_addr_pullup,
    .special_pin_in, .special_pin_out, .special_pin_oe, .special_pullup);
  pin_partner board (.mclk, .addr_data_pin_out, .addr_data_pin_oe, .high_addr_pin_out, .high_addr_pin_oe,
    .high_addr_pullup, .special_pin_out, .special_pin_oe, .special_pullup, .p0_en, .p0_val, .p1_en, .p1_val,
    .p2_en, .p2_val, .p3_en, .p3_val, .addr_data_pin_in, .analog_pin_in, .high_addr_pin_in, .special_pin_in);

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    cyc(1);
    latch_wr = 1'b1;
    wr_port = p;
    wr_data = d;
    cyc(1);
    latch_wr = 1'b0;
  endtask
  // lw set alongside shows which of the two writes wins
  task automatic bw(input logic [1:0] p, input logic [2:0] i, input logic v, input logic lw, input logic [7:0] d);
    cyc(1);
    bit_wr = 1'b1;
    latch_wr = lw;
    wr_port = p;
    bit_idx = i;
    bit_val = v;
    wr_data = d;
    cyc(1);
    bit_wr = 1'b0;
    latch_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] p, input logic cls, input logic [7:0] exp);
    cyc(1);
    rd_req = 1'b1;
    rd_port = p;
    rd_latch_class = cls;
    cyc(1);
    rd_req = 1'b0;
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask
  task automatic do_reset;
    nrst = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
  endtask
  task automatic conclude;
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {latch_wr, bit_wr, bit_val, rd_req, rd_latch_class, ext_mem_active, ext_addr_high_active} = 7'h00;
    {pwm_on_high_port, pwm_on_special_port, pwm0, pwm1, shift_mode, shift_data_out} = 6'h00;
    {ext_wr_n, ext_rd_n, serial_tx_out, shift_clk_out} = 4'hf;
    {wr_port, rd_port, bit_idx} = 7'h00;
    {wr_data, ext_addr_data_out, ext_addr_high} = 24'h000000;
    {p0_en, p0_val, p1_en, p1_val, p2_en, p2_val, p3_en, p3_val} = 64'h0;
    do_reset();
    rd(PORT_ADDR_DATA, 1'b1, LATCH_RESET);
    rd(PORT_HIGH_ADDR, 1'b1, 8'hff);
    rd(PORT_SPECIAL, 1'b1, 8'hff);
    rd(PORT_ANALOG, 1'b1, 8'hff);
    chk(analog_select, 8'hff);
    chk(addr_data_pin_oe, 8'h00);
    chk(high_addr_pullup, 8'hff);
    wr(PORT_ADDR_DATA, 8'h5a);
    chk(addr_data_pin_oe, 8'ha5);
    chk(addr_data_pin_out, 8'h00);
    {p0_en, p0_val} = 16'h5a18;
    rd(PORT_ADDR_DATA, 1'b1, 8'h5a);
    cyc(3);
    rd(PORT_ADDR_DATA, 1'b0, 8'h18);
    wr(PORT_HIGH_ADDR, 8'h3c);
    chk(high_addr_pin_oe, 8'hc3);
    chk(high_addr_pullup, 8'h3c);
    bw(PORT_HIGH_ADDR, 3'h7, 1'b1, 1'b0, 8'h00);
    rd(PORT_HIGH_ADDR, 1'b1, 8'hbc);
    bw(PORT_HIGH_ADDR, 3'h2, 1'b1, 1'b1, 8'h81);
    rd(PORT_HIGH_ADDR, 1'b1, 8'h81);
    // analog port pins become digital inputs
    wr(PORT_ANALOG, 8'h00);
    chk(analog_select, 8'h00);
    {p1_en, p1_val} = 16'hff23;
    cyc(3);
    chk({5'h00, slave_select_n, third_timer_trigger_input, third_timer_count_input}, 8'h07);
    rd(PORT_ANALOG, 1'b0, 8'h23);
    p1_val = 8'h00;
    cyc(3);
    chk({5'h00, slave_select_n, third_timer_trigger_input, third_timer_count_input}, 8'h00);
    {p3_en, p3_val} = 16'hff55;
    cyc(3);
    chk({2'h0, second_timer_count_input, first_timer_count_input, external_interrupt_one, external_interrupt_zero,
      1'b0, serial_rx_in}, 8'h15);
    rd(PORT_SPECIAL, 1'b0, 8'h55);
    rd(PORT_SPECIAL, 1'b1, 8'hff);
    p3_en = 8'h00;
    // special port: alternate outputs gated by latch
    wr(PORT_SPECIAL, 8'h0f);
    chk(special_pin_oe, 8'hf0);
    chk(special_pullup, 8'h0f);
    chk(special_pin_out, 8'h00);
    serial_tx_out = 1'b0;
    ext_wr_n = 1'b0;
    cyc(1);
    chk(special_pin_oe, 8'hf2);
    wr(PORT_SPECIAL, 8'hff);
    chk(special_pin_oe, 8'h42);
    {ext_rd_n, serial_tx_out, ext_wr_n, shift_mode, shift_clk_out} = 5'h0f;
    cyc(1);
    chk(special_pin_oe, 8'h81);
    shift_clk_out = 1'b0;
    cyc(1);
    chk(special_pin_oe, 8'h83);
    {ext_rd_n, shift_mode, shift_clk_out} = 3'h5;
    cyc(1);
    chk(special_pin_oe, 8'h00);
    // pwm routing; latches untouched while pwm owns the pins
    wr(PORT_SPECIAL, 8'he7);
    {pwm_on_special_port, pwm1, pwm0} = 3'h6;
    cyc(1);
    chk(special_pin_oe, 8'h10);
    chk(special_pullup, 8'hef);
    {pwm_on_high_port, pwm1, pwm0} = 3'h5;
    cyc(1);
    chk(high_addr_pin_oe, 8'hbe);
    chk(special_pin_oe, 8'h08);
    {pwm_on_high_port, pwm_on_special_port} = 2'h0;
    cyc(1);
    chk(high_addr_pin_oe, 8'h7e);
    // external memory access
    p0_en = 8'h00;
    {ext_mem_active, ext_addr_data_out} = 9'h196;
    cyc(1);
    chk(addr_data_pin_oe, 8'hff);
    chk(addr_data_pin_out, 8'h96);
    wr(PORT_ADDR_DATA, 8'h00);
    rd(PORT_ADDR_DATA, 1'b1, ADDR_DATA_ACCESS_FILL);
    ext_addr_data_out = 8'h3c;
    {ext_addr_high_active, ext_addr_high} = 9'h112;
    cyc(1);
    chk(addr_data_pin_out, 8'h3c);
    chk(high_addr_pin_oe, 8'hff);
    chk(high_addr_pin_out, 8'h12);
    chk(high_addr_pullup, 8'h00);
    {ext_mem_active, ext_addr_high_active} = 2'h0;
    cyc(1);
    chk(addr_data_pin_oe, 8'h00);
    chk(high_addr_pin_oe, 8'h7e);
    rd(PORT_HIGH_ADDR, 1'b1, 8'h81);
    {p0_en, p0_val} = 16'hffc3;
    cyc(4);
    chk(ext_data_in, 8'hc3);
    // reset again in mid-run
    do_reset();
    rd(PORT_ANALOG, 1'b1, 8'hff);
    rd(PORT_SPECIAL, 1'b1, 8'hff);
    rd(PORT_HIGH_ADDR, 1'b1, LATCH_RESET);
    conclude();
  end

  initial
  begin
    #40000;
    n_fail++;
    conclude();
  end
endmodule
